/* src/pec_pkg.sv */
// pec_pkg: constants for the link event counter log page framer.
// assumes: one 10 MHz system clock, byte-wide page stream toward the host.
package pec_pkg;
  // ----------------------------------------
  // page layout
  // ----------------------------------------
  localparam int unsigned PEC_PAGE_BYTES = 512;
  localparam int unsigned PEC_HDR_BYTES = 4;
  localparam logic [8:0] PEC_LAST_IDX = 9'h1FF;
  localparam logic [8:0] PEC_FIRST_ENTRY = 9'h004;
  localparam int unsigned PEC_ID_SIZE_LSB = 12;
  localparam logic [2:0] PEC_SIZE_16 = 3'h1;
  localparam logic [2:0] PEC_SIZE_32 = 3'h2;
  localparam logic [2:0] PEC_SIZE_48 = 3'h3;
  localparam logic [2:0] PEC_SIZE_64 = 3'h4;
  localparam logic [15:0] PEC_ID_END = 16'h0000;
  // ----------------------------------------
  // capability word
  // ----------------------------------------
  localparam int unsigned PEC_CAP_BIT = 10;
  localparam logic [15:0] PEC_CAP_WORD = 16'h0400;
  // ----------------------------------------
  // framer states
  // ----------------------------------------
  typedef enum logic [1:0] {PEC_IDLE, PEC_SEND, PEC_SUM} pec_state_t;
endpackage : pec_pkg

/* src/pec_counter.sv */
// pec_counter: one saturating event counter, zero-extended to 64 bits until it saturates.
// assumes: event and clear pulses are synchronous to clk_sys_in.
`timescale 1ns/1ns
module pec_counter #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // control
  input wire logic event_in,
  input wire logic clear_in,
  // value
  output logic [63:0] value_out
);
  import pec_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } pec_cnt_state_t;

  pec_cnt_state_t state_reg;
  pec_cnt_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (clear_in)
      state_next.count = '0;
    else if (event_in && !(&state_reg.count))
      state_next.count = state_reg.count + WIDTH'(1);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // saturated counter reads as all ones across the whole field
  always_comb
  begin
    value_out = 64'h0;
    value_out[WIDTH-1:0] = state_reg.count;
    if (&state_reg.count)
      value_out = 64'hFFFF_FFFF_FFFF_FFFF;
  end
endmodule : pec_counter

/* src/pec_log_page.sv */
// pec_log_page: event counters and the 512-byte log page built from them.
// the page streams one byte per cycle and ends with its checksum byte.
// assumes: a command decoder pulses read_req_in; the host takes one byte per
// cycle while page_valid_out is high; no back-pressure on the byte stream.
// assumes: power-on reset is the only reset wired to reset_n_in.
`timescale 1ns/1ns
module pec_log_page #(
  parameter int unsigned NUM_CNT = 4,
  parameter logic [NUM_CNT*12-1:0] CNT_CODE = {12'h00A, 12'h009, 12'h002, 12'h001},
  parameter logic [NUM_CNT*3-1:0] CNT_SIZE = {3'h1, 3'h1, 3'h2, 3'h1},
  parameter logic [NUM_CNT*7-1:0] CNT_WIDTH = {7'd8, 7'd16, 7'd32, 7'd16}
) (
  // clock and power-on reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // events
  input wire logic [NUM_CNT-1:0] event_in,
  input wire logic bist_activate_in,
  // page request
  input wire logic read_req_in,
  input wire logic reset_after_read_in,
  // page stream
  output logic page_valid_out,
  output logic [7:0] page_byte_out,
  output logic [8:0] page_index_out,
  output logic page_last_out,
  // identification
  output logic [15:0] cap_word_out
);
  import pec_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pec_state_t fsm;
    logic [8:0] idx;
    logic [7:0] sum;
    logic clr_after;
    logic clr;
    logic valid;
    logic [7:0] data;
    logic [8:0] data_idx;
    logic last;
    logic [15:0] cap;
  } pec_top_state_t;

  pec_top_state_t state_reg;
  pec_top_state_t state_next;

  logic [NUM_CNT-1:0][63:0] cnt_value;

  logic [9:0] entry_start [NUM_CNT];
  logic entry_hit [NUM_CNT];
  logic [7:0] entry_byte [NUM_CNT];
  logic [7:0] cur_byte;

  // ----------------------------------------
  // counters and entries
  // ----------------------------------------
  // of the resets reset_n_in (power-on) and reset_after_read_in clear them, as does bist_activate_in; link resets do not reach here
  assign entry_start[0] = 10'(PEC_FIRST_ENTRY);

  generate
    for (genvar i = 0; i < NUM_CNT; i++)
    begin : g_cnt
      // per-entry constants: size code and whole entry length in bytes
      localparam logic [2:0] SIZE = CNT_SIZE[i*3 +: 3];
      localparam logic [9:0] LEN = 10'(2 + 2 * int'(SIZE));
      logic [127:0] slot;
      logic [9:0] rel;

      pec_counter #(
        .WIDTH(int'(CNT_WIDTH[i*7 +: 7]))
      ) u_cnt (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .event_in(event_in[i]),
        .clear_in(state_reg.clr || bist_activate_in),
        .value_out(cnt_value[i])
      );

      // entry image: identifier then value, both little-endian, zero above
      always_comb
      begin
        slot = '0;
        slot[15:0] = {1'b0, SIZE, CNT_CODE[i*12 +: 12]};
        case (SIZE)
          PEC_SIZE_16: slot[31:16] = cnt_value[i][15:0];
          PEC_SIZE_32: slot[47:16] = cnt_value[i][31:0];
          PEC_SIZE_48: slot[63:16] = cnt_value[i][47:0];
          default: slot[79:16] = cnt_value[i];
        endcase
      end

      // offset into this entry; below the entry start it wraps far past LEN
      assign rel = {1'b0, state_reg.idx} - entry_start[i];
      assign entry_hit[i] = (rel < LEN);
      assign entry_byte[i] = slot[rel[3:0]*8 +: 8];

      // entries sit back to back, so the next one starts where this one ends
      if (i + 1 < NUM_CNT)
      begin : g_next
        assign entry_start[i+1] = entry_start[i] + LEN;
      end
    end
  endgenerate

  // ----------------------------------------
  // byte selection
  // ----------------------------------------
  // header zero, packed entries, then terminator and zero fill up to the checksum
  always_comb
  begin
    cur_byte = 8'h00;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (entry_hit[i])
        cur_byte = entry_byte[i];
    end
    // the header stays reserved whatever the entry logic says
    if (state_reg.idx < PEC_FIRST_ENTRY)
      cur_byte = 8'h00;
  end

  // ----------------------------------------
  // framer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.valid = 1'b0;
    state_next.last = 1'b0;
    state_next.clr = 1'b0;
    state_next.cap = PEC_CAP_WORD;
    case (state_reg.fsm)
      PEC_IDLE:
      begin
        // a request while a page streams is ignored, not queued
        if (read_req_in)
        begin
          state_next.fsm = PEC_SEND;
          state_next.idx = 9'h000;
          state_next.sum = 8'h00;
          state_next.clr_after = reset_after_read_in;
        end
      end
      PEC_SEND:
      begin
        state_next.valid = 1'b1;
        state_next.data = cur_byte;
        state_next.data_idx = state_reg.idx;
        // sum the byte as sent, so counters moving mid-page keep the page valid
        state_next.sum = state_reg.sum + cur_byte;
        state_next.idx = state_reg.idx + 9'h001;
        if (state_reg.idx == PEC_LAST_IDX - 9'h001)
          state_next.fsm = PEC_SUM;
      end
      PEC_SUM:
      begin
        state_next.valid = 1'b1;
        state_next.last = 1'b1;
        state_next.data = 8'h00 - state_reg.sum;
        state_next.data_idx = PEC_LAST_IDX;
        // the clear lands after the checksum byte, so this page shows old values
        state_next.clr = state_reg.clr_after;
        state_next.fsm = PEC_IDLE;
      end
      default:
        state_next.fsm = PEC_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg.fsm <= PEC_IDLE;
      state_reg.idx <= 9'h000;
      state_reg.sum <= 8'h00;
      state_reg.clr_after <= 1'b0;
      state_reg.clr <= 1'b0;
      state_reg.valid <= 1'b0;
      state_reg.data <= 8'h00;
      state_reg.data_idx <= 9'h000;
      state_reg.last <= 1'b0;
      state_reg.cap <= PEC_CAP_WORD;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign page_valid_out = state_reg.valid;
  assign page_byte_out = state_reg.data;
  assign page_index_out = state_reg.data_idx;
  assign page_last_out = state_reg.last;
  assign cap_word_out = state_reg.cap;
endmodule : pec_log_page

/* bench/pec_log_page_props.sv */
// pec_log_page_props: assertions on the log page framer ports.
// assumes: the default list of four counters, so the entries end at byte 21.
`timescale 1ns/1ns
module pec_log_page_props #(
  parameter int unsigned NUM_CNT = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // inputs
  input wire logic [NUM_CNT-1:0] event_in,
  input wire logic bist_activate_in,
  input wire logic read_req_in,
  input wire logic reset_after_read_in,
  // outputs
  input wire logic page_valid_out,
  input wire logic [7:0] page_byte_out,
  input wire logic [8:0] page_index_out,
  input wire logic page_last_out,
  input wire logic [15:0] cap_word_out
);
  logic [7:0] sum_reg;
  // running sum of the bytes sent so far in this page
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in)
      sum_reg <= 8'h00;
    else if (page_valid_out)
      sum_reg <= ((page_index_out == 9'h000) ? 8'h00 : sum_reg) + page_byte_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence req_s; read_req_in && !page_valid_out; endsequence
  sequence first_s; page_valid_out && page_index_out == 9'h000; endsequence
  cap_word_a: assert property ($past(reset_n_in) |-> cap_word_out == 16'h0400)
    else $error("capability word wrong");
  req_start_a: assert property (req_s |-> ##2 first_s)
    else $error("page did not start two cycles after request");
  index_step_a: assert property (page_valid_out && !page_last_out |=> page_valid_out
    && page_index_out == $past(page_index_out) + 9'h001) else $error("index not stepping");
  last_end_a: assert property (page_last_out |-> page_index_out == 9'h1FF ##1 !page_valid_out)
    else $error("page length wrong");
  hdr_zero_a: assert property (page_valid_out && page_index_out < 9'h004
    |-> page_byte_out == 8'h00) else $error("header byte not zero");
  size_code_a: assert property (page_valid_out && page_index_out == 9'h005
    |-> page_byte_out == 8'h10) else $error("size code wrong");
  tail_zero_a: assert property (page_valid_out && page_index_out > 9'h015 && !page_last_out
    |-> page_byte_out == 8'h00) else $error("byte after list not zero");
  checksum_a: assert property (page_last_out |-> sum_reg + page_byte_out == 8'h00)
    else $error("checksum wrong");
endmodule : pec_log_page_props
bind pec_log_page pec_log_page_props #(.NUM_CNT(NUM_CNT)) props (.clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in), .event_in(event_in), .bist_activate_in(bist_activate_in),
  .read_req_in(read_req_in), .reset_after_read_in(reset_after_read_in),
  .page_valid_out(page_valid_out), .page_byte_out(page_byte_out),
  .page_index_out(page_index_out), .page_last_out(page_last_out), .cap_word_out(cap_word_out));

/* bench/pec_host_model.sv */
// pec_host_model: host side taking the page stream into a buffer.
// assumes: one byte per cycle while valid, the host never stalls.
`timescale 1ns/1ns
module pec_host_model (
  // clock
  input wire logic clk_sys_in,
  // page stream
  input wire logic valid_in,
  input wire logic [7:0] byte_in,
  input wire logic [8:0] index_in,
  // page summary
  output logic [7:0] sum_out,
  output logic [9:0] count_out
);
  logic [7:0] mem [512];
  always_ff @(posedge clk_sys_in)
    if (valid_in)
    begin
      mem[index_in] <= byte_in;
      sum_out <= ((index_in == 9'h000) ? 8'h00 : sum_out) + byte_in;
      count_out <= (index_in == 9'h000) ? 10'h001 : count_out + 10'h001;
    end
endmodule : pec_host_model

/* bench/pec_log_page_test.sv */
// pec_log_page_test: self-checking bench for the log page framer.
// assumes: default counter list; the host model keeps the last page.
`timescale 1ns/1ns
module pec_log_page_test;
  logic clk_sys_in, reset_n_in, bist_activate_in, read_req_in, reset_after_read_in;
  logic page_valid_out, page_last_out;
  logic [3:0] event_in;
  logic [7:0] page_byte_out, sum;
  logic [8:0] page_index_out;
  logic [9:0] count;
  logic [15:0] cap_word_out;
  int err_total, checks_done, cycles;
  pec_log_page dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .event_in(event_in),
    .bist_activate_in(bist_activate_in), .read_req_in(read_req_in),
    .reset_after_read_in(reset_after_read_in), .page_valid_out(page_valid_out),
    .page_byte_out(page_byte_out), .page_index_out(page_index_out),
    .page_last_out(page_last_out), .cap_word_out(cap_word_out));
  pec_host_model host (.clk_sys_in(clk_sys_in), .valid_in(page_valid_out),
    .byte_in(page_byte_out), .index_in(page_index_out), .sum_out(sum), .count_out(count));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_total++;
      test_done();
    end
  end
  function automatic logic [31:0] wd(int i, int n);
    wd = 32'h0;
    for (int k = n - 1; k >= 0; k--) wd = {wd[23:0], host.mem[i + k]};
  endfunction : wd
  task ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck
  task read_page(input logic rar);
    @(posedge clk_sys_in) read_req_in <= 1'b1;
    reset_after_read_in <= rar;
    @(posedge clk_sys_in) read_req_in <= 1'b0;
    reset_after_read_in <= 1'b0;
    for (int k = 0; k < 600 && page_last_out !== 1'b1; k++) @(negedge clk_sys_in);
    repeat (2) @(negedge clk_sys_in);
  endtask : read_page
  task pulse(input logic [3:0] m, input int n);
    @(posedge clk_sys_in) event_in <= m;
    repeat (n) @(posedge clk_sys_in);
    event_in <= 4'h0;
  endtask : pulse
  task ck_page(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
    input logic [31:0] d);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 22; i < 511; i++) acc = acc | host.mem[i];
    ck(wd(0, 4), 32'h0);
    ck(wd(4, 2) ^ wd(8, 2) << 16, 32'h20021001);
    ck(wd(14, 2) ^ wd(18, 2) << 16, 32'h100A1009);
    ck(wd(6, 2) + (wd(16, 2) << 16), a);
    ck(wd(10, 4), b);
    ck(wd(12, 2), c);
    ck(wd(20, 2), d);
    ck(wd(22, 2) + 32'(acc), 32'h0);
    ck(32'(sum), 32'h0);
    ck(32'(count), 32'd512);
  endtask : ck_page
  task t_count;
    pulse(4'h7, 5);
    pulse(4'h4, 2);
    read_page(1'b0);
    ck_page(32'h00070005, 32'h5, 32'h0, 32'h0);
  endtask : t_count
  task t_sat;
    pulse(4'h8, 260);
    read_page(1'b1);
    ck_page(32'h00070005, 32'h5, 32'h0, 32'hFFFF);
    read_page(1'b0);
    ck_page(32'h0, 32'h0, 32'h0, 32'h0);
  endtask : t_sat
  task t_bist;
    pulse(4'hF, 3);
    @(posedge clk_sys_in) bist_activate_in <= 1'b1;
    @(posedge clk_sys_in) bist_activate_in <= 1'b0;
    read_page(1'b0);
    ck_page(32'h0, 32'h0, 32'h0, 32'h0);
  endtask : t_bist
  task t_power;
    pulse(4'hF, 2);
    @(posedge clk_sys_in) reset_n_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(negedge clk_sys_in);
    ck(32'(cap_word_out), 32'h0400);
    read_page(1'b0);
    ck_page(32'h0, 32'h0, 32'h0, 32'h0);
  endtask : t_power
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial
  begin
    {reset_n_in, bist_activate_in, read_req_in, reset_after_read_in, event_in} = '0;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(negedge clk_sys_in);
    ck(32'(cap_word_out), 32'h0400);
    t_count();
    t_sat();
    t_bist();
    t_power();
    test_done();
  end
endmodule : pec_log_page_test
